// ---- hsmon_readback.sv ----
/*
  Serial readback and status of a hot swap power monitor: read-only I2C
  slave on its own SCL domain, command, alert enable and hotswap_control
  registers written through strobes, live and sticky alert flags.
  Assumes write transfers are decoded elsewhere and delivered as strobes
  on clk, the ADC delivers codes with one-cycle done pulses on clk, and
  the SDA wire is resolved outside from sdaOe.
*/
// Functional notes
// - software_power_off forces hot swap off like pin
// - combined read: V high, I high, nibbles
// - voltage read: V high, V low nibble, zeros
// - current read: I high, I low nibble, zeros
// - read frame: address ack, master acks, nack, stop
// - voltage code linear over 4096 full-scale steps
// - current code linear over 105.84 mV span
// - status read returns one acknowledged status byte
// - bit 0: last three conversions over threshold
// - bit 1: adc overcurrent sticky until clear
// - bit 2: live analog overcurrent trip state
// - bit 3: swap failed sticky until clear
// - bit 4: pin off or software off
// - bit 5: power disabled alert sticky
// - status_select makes reads return status byte
// - clear bit clears stickies, self-clears
// - continuous: ack zeros; single-shot: nack until done
// - command bits select continuous or single-shot
`include "hsmon_regs.svh"

module hsmon_readback (
  input wire logic clk,
  input wire logic nrst,
  input wire logic scl,
  input wire logic sdaIn,
  output logic sdaOut,
  output logic sdaOe,
  input wire logic [6:0] slaveAddr,
  input wire logic powerEnablePin,
  input wire logic cmdWrite,
  input wire logic [7:0] cmdData,
  input wire logic alertEnWrite,
  input wire logic [7:0] alertEnData,
  input wire logic threshWrite,
  input wire logic [7:0] threshData,
  input wire logic ctrlWrite,
  input wire logic [7:0] ctrlData,
  input wire logic voltDone,
  input wire logic [11:0] voltCode,
  input wire logic ampDone,
  input wire logic [11:0] ampCode,
  input wire logic analogTrip,
  input wire logic swapFailEvent,
  output logic hotswapOff,
  output logic voltConvertEn,
  output logic ampConvertEn,
  output logic voltSpanSelect,
  output logic clearPending,
  output logic [7:0] statusByte
);

  // ==========================================================
  // link domain: sample SDA on each SCL rise
  logic linkBit_q;

  // held until the next SCL rise; clk reads it after the synced rise
  always_ff @(posedge scl) begin
    linkBit_q <= sdaIn;
  end

  // ==========================================================
  // synchronisers into clk
  logic [1:0] sclSync_q;
  logic [1:0] sdaSync_q;
  logic [1:0] pinSync_q;
  logic sclPrev_q;
  logic sdaPrev_q;

  always_ff @(posedge clk) begin
    if (!nrst) begin
      sclSync_q <= 2'h3;
      sdaSync_q <= 2'h3;
      pinSync_q <= 2'h0;
      sclPrev_q <= 1'b1;
      sdaPrev_q <= 1'b1;
    end else begin
      sclSync_q <= {sclSync_q[0], scl};
      sdaSync_q <= {sdaSync_q[0], sdaIn};
      pinSync_q <= {pinSync_q[0], powerEnablePin};
      sclPrev_q <= sclSync_q[1];
      sdaPrev_q <= sdaSync_q[1];
    end
  end

  logic sampleEv;
  logic sclFall;
  logic startEv;
  logic stopEv;
  assign sampleEv = sclSync_q[1] & ~sclPrev_q;
  assign sclFall = sclPrev_q & ~sclSync_q[1];
  assign startEv = sclSync_q[1] & sclPrev_q & sdaPrev_q & ~sdaSync_q[1];
  assign stopEv = sclSync_q[1] & sclPrev_q & ~sdaPrev_q & sdaSync_q[1];

  // ==========================================================
  // command, alert enable, threshold and control registers
  logic [7:0] cmd_q;
  logic [3:0] alertEn_q;
  logic [7:0] thresh_q;
  logic [7:0] hotswapControl_q;
  logic clear_q;
  logic voltOnce_q;
  logic ampOnce_q;

  always_ff @(posedge clk) begin
    if (!nrst) begin
      cmd_q <= `HSMON_CMD_RESET;
    end else if (cmdWrite) begin
      cmd_q <= cmdData;
    end
  end

  // single-shot requests self-clear once their conversion is done
  always_ff @(posedge clk) begin
    if (!nrst) begin
      voltOnce_q <= 1'b0;
      ampOnce_q <= 1'b0;
    end else if (cmdWrite) begin
      voltOnce_q <= cmdData[`HSMON_CMD_VOLT_ONCE];
      ampOnce_q <= cmdData[`HSMON_CMD_AMP_ONCE];
    end else begin
      if (voltDone) voltOnce_q <= 1'b0;
      if (ampDone) ampOnce_q <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      alertEn_q <= `HSMON_AEN_RESET;
      clear_q <= 1'b0;
    end else if (alertEnWrite) begin
      alertEn_q <= alertEnData[3:0];
      clear_q <= alertEnData[`HSMON_AEN_CLEAR];
    end else begin
      clear_q <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      thresh_q <= `HSMON_THRESH_RESET;
    end else if (threshWrite) begin
      thresh_q <= threshData;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      hotswapControl_q <= `HSMON_CTRL_RESET;
    end else if (ctrlWrite) begin
      hotswapControl_q <= ctrlData;
    end
  end

  logic softwarePowerOff;
  assign softwarePowerOff = hotswapControl_q[`HSMON_CTRL_SW_OFF];
  assign hotswapOff = ~pinSync_q[1] | softwarePowerOff;
  assign voltConvertEn = cmd_q[`HSMON_CMD_VOLT_REPEAT] | voltOnce_q;
  assign ampConvertEn = cmd_q[`HSMON_CMD_AMP_REPEAT] | ampOnce_q;
  assign voltSpanSelect = cmd_q[`HSMON_CMD_VOLT_SPAN];
  assign clearPending = clear_q;

  // ==========================================================
  // conversion results; zero until the first conversion
  hsmon_pkg::hsmon_conv_t volt_q;
  hsmon_pkg::hsmon_conv_t amp_q;

  always_ff @(posedge clk) begin
    if (!nrst) begin
      volt_q <= '0;
      amp_q <= '0;
    end else begin
      if (voltDone) volt_q <= {1'b1, voltCode};
      if (ampDone) amp_q <= {1'b1, ampCode};
    end
  end

  // ==========================================================
  // alert flags
  logic [2:0] overHist_q;
  logic adcSticky_q;
  logic swapSticky_q;
  logic offSticky_q;
  logic offPrev_q;
  logic ampOver;
  logic adcTrip;
  logic offRise;

  assign ampOver = ampCode[11:4] > thresh_q;
  assign adcTrip = ampDone & ((alertEn_q[`HSMON_AEN_OC_ONE] & ampOver) |
                   (alertEn_q[`HSMON_AEN_OC_FOUR] & ampOver & (&overHist_q[2:0])));
  assign offRise = hotswapOff & ~offPrev_q;

  always_ff @(posedge clk) begin
    if (!nrst) begin
      overHist_q <= 3'h0;
      offPrev_q <= 1'b0;
    end else begin
      if (ampDone) overHist_q <= {overHist_q[1:0], ampOver};
      offPrev_q <= hotswapOff;
    end
  end

  // a new event wins over a clear in the same cycle
  always_ff @(posedge clk) begin
    if (!nrst) begin
      adcSticky_q <= 1'b0;
      swapSticky_q <= 1'b0;
      offSticky_q <= 1'b0;
    end else begin
      if (adcTrip) adcSticky_q <= 1'b1;
      else if (clear_q) adcSticky_q <= 1'b0;
      if (swapFailEvent & alertEn_q[`HSMON_AEN_SWAP_FAIL]) swapSticky_q <= 1'b1;
      else if (clear_q) swapSticky_q <= 1'b0;
      if (offRise & alertEn_q[`HSMON_AEN_OFF]) offSticky_q <= 1'b1;
      else if (clear_q) offSticky_q <= 1'b0;
    end
  end

  hsmon_pkg::hsmon_status_t status;
  always_comb begin
    status.spare = 2'h0;
    status.powerDisabledSticky = offSticky_q;
    status.powerDisabledState = hotswapOff;
    status.swapFailedSticky = swapSticky_q;
    status.analogTripState = analogTrip;
    status.adcOvercurrentSticky = adcSticky_q;
    status.adcOvercurrentNow = &overHist_q[2:0];
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      statusByte <= 8'h00;
    end else begin
      statusByte <= status;
    end
  end

  // ==========================================================
  // readback byte selection
  function automatic logic [7:0] pickByte(input hsmon_pkg::hsmon_fmt_t fmt, input logic [1:0] idx,
                                          input logic [11:0] v, input logic [11:0] i, input logic [7:0] st);
    logic [7:0] b;
    b = 8'h00;
    case (fmt)
      hsmon_pkg::FMT_BOTH: begin
        if (idx == 2'h0) b = v[11:4];
        else if (idx == 2'h1) b = i[11:4];
        else b = {v[3:0], i[3:0]};
      end
      hsmon_pkg::FMT_VOLT: begin
        b = (idx == 2'h0) ? v[11:4] : {v[3:0], 4'h0};
      end
      hsmon_pkg::FMT_AMP: begin
        b = (idx == 2'h0) ? i[11:4] : {i[3:0], 4'h0};
      end
      default: begin
        b = st;
      end
    endcase
    return b;
  endfunction : pickByte

  hsmon_pkg::hsmon_fmt_t fmtNow;
  always_comb begin
    if (cmd_q[`HSMON_CMD_STATUS_SEL]) begin
      fmtNow = hsmon_pkg::FMT_STATUS;
    end else if (voltConvertEn & ~ampConvertEn) begin
      fmtNow = hsmon_pkg::FMT_VOLT;
    end else if (ampConvertEn & ~voltConvertEn) begin
      fmtNow = hsmon_pkg::FMT_AMP;
    end else begin
      fmtNow = hsmon_pkg::FMT_BOTH;
    end
  end

  logic readBusy;
  assign readBusy = ~cmd_q[`HSMON_CMD_STATUS_SEL] & (voltOnce_q | ampOnce_q);

  // ==========================================================
  // link state machine
  hsmon_pkg::hsmon_state_t state_q;
  hsmon_pkg::hsmon_fmt_t fmt_q;
  logic [2:0] bitCnt_q;
  logic [7:0] shift_q;
  logic [1:0] byteIdx_q;
  logic [11:0] snapV_q;
  logic [11:0] snapI_q;
  logic [7:0] snapSt_q;
  logic drive_q;
  logic lastByte;

  assign lastByte = (fmt_q == hsmon_pkg::FMT_BOTH) ? (byteIdx_q == 2'h2) : (byteIdx_q == 2'h1);

  logic [7:0] nextByte;
  assign nextByte = pickByte(fmt_q, byteIdx_q, snapV_q, snapI_q, snapSt_q);

  always_ff @(posedge clk) begin
    if (!nrst) begin
      state_q <= hsmon_pkg::ST_IDLE;
      fmt_q <= hsmon_pkg::FMT_BOTH;
      bitCnt_q <= 3'h0;
      shift_q <= 8'h00;
      byteIdx_q <= 2'h0;
      snapV_q <= 12'h000;
      snapI_q <= 12'h000;
      snapSt_q <= 8'h00;
      drive_q <= 1'b0;
    end else if (startEv) begin
      state_q <= hsmon_pkg::ST_ADDR;
      bitCnt_q <= 3'h0;
      drive_q <= 1'b0;
    end else if (stopEv) begin
      state_q <= hsmon_pkg::ST_IDLE;
      drive_q <= 1'b0;
    end else begin
      case (state_q)
        hsmon_pkg::ST_ADDR: begin
          if (sampleEv) begin
            shift_q <= {shift_q[6:0], linkBit_q};
            bitCnt_q <= bitCnt_q + 3'h1;
            if (bitCnt_q == 3'h7) begin
              // address plus read bit, refused while a single shot runs unless status is selected
              if ({shift_q[6:0], linkBit_q} == {slaveAddr, 1'b1} && !readBusy) begin
                state_q <= hsmon_pkg::ST_ACK;
                fmt_q <= fmtNow;
                snapV_q <= volt_q.code;
                snapI_q <= amp_q.code;
                snapSt_q <= status;
                byteIdx_q <= 2'h0;
              end else begin
                state_q <= hsmon_pkg::ST_WAIT;
              end
            end
          end
        end
        hsmon_pkg::ST_ACK: begin
          if (sclFall) begin
            drive_q <= 1'b1;
            state_q <= hsmon_pkg::ST_LOAD;
          end
        end
        hsmon_pkg::ST_LOAD: begin
          if (sclFall) begin
            shift_q <= nextByte;
            drive_q <= ~nextByte[7];
            bitCnt_q <= 3'h0;
            state_q <= hsmon_pkg::ST_SEND;
          end
        end
        hsmon_pkg::ST_SEND: begin
          if (sclFall) begin
            bitCnt_q <= bitCnt_q + 3'h1;
            if (bitCnt_q == 3'h7) begin
              drive_q <= 1'b0;
              state_q <= hsmon_pkg::ST_MACK;
            end else begin
              shift_q <= {shift_q[6:0], 1'b0};
              drive_q <= ~shift_q[6];
            end
          end
        end
        hsmon_pkg::ST_MACK: begin
          if (sampleEv) begin
            if (!linkBit_q && fmt_q != hsmon_pkg::FMT_STATUS) begin
              // master ack: next byte, format repeats after its last
              byteIdx_q <= lastByte ? 2'h0 : byteIdx_q + 2'h1;
              state_q <= hsmon_pkg::ST_LOAD;
            end else begin
              // nack, or acked single status byte: free the line for stop
              state_q <= hsmon_pkg::ST_WAIT;
            end
          end
        end
        hsmon_pkg::ST_WAIT: begin
          drive_q <= 1'b0;
        end
        default: begin
          state_q <= hsmon_pkg::ST_IDLE;
          drive_q <= 1'b0;
        end
      endcase
    end
  end

  // open drain: only ever pull low
  assign sdaOut = 1'b0;
  assign sdaOe = drive_q;

endmodule : hsmon_readback

// ---- hsmon_regs.svh ----
/*
  Constants of the hot swap monitor readback block: field positions,
  reset values, link widths and scaling figures.
  Assumes it is included by its bare name from the package and the module.
*/
`ifndef HSMON_REGS_SVH
`define HSMON_REGS_SVH

// ==========================================================
// command byte fields
`define HSMON_CMD_VOLT_REPEAT 0
`define HSMON_CMD_VOLT_ONCE 1
`define HSMON_CMD_AMP_REPEAT 2
`define HSMON_CMD_AMP_ONCE 3
`define HSMON_CMD_VOLT_SPAN 4
`define HSMON_CMD_STATUS_SEL 6
`define HSMON_CMD_RESET 8'h00

// ==========================================================
// alert enable fields
`define HSMON_AEN_OC_ONE 0
`define HSMON_AEN_OC_FOUR 1
`define HSMON_AEN_SWAP_FAIL 2
`define HSMON_AEN_OFF 3
`define HSMON_AEN_CLEAR 4
`define HSMON_AEN_RESET 4'h4

// ==========================================================
// hotswap_control fields
`define HSMON_CTRL_SW_OFF 0
`define HSMON_CTRL_RESET 8'h00

// ==========================================================
// alert threshold reset
`define HSMON_THRESH_RESET 8'hFF

// ==========================================================
// conversion scaling
`define HSMON_CODE_STEPS 4096
`define HSMON_VFS_NARROW_MV 6650
`define HSMON_VFS_WIDE_MV 26350
`define HSMON_IFS_UV 105840

// ==========================================================
// link
`define HSMON_ADDR_BITS 7
`define HSMON_BYTE_BITS 8

`endif

// ---- hsmon_pkg.sv ----
/*
  Types of the hot swap monitor readback block.
  Assumes hsmon_regs.svh is on the include path.
*/
`include "hsmon_regs.svh"

package hsmon_pkg;

  // ==========================================================
  // link states
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ADDR = 3'b001,
    ST_ACK = 3'b010,
    ST_LOAD = 3'b011,
    ST_SEND = 3'b100,
    ST_MACK = 3'b101,
    ST_WAIT = 3'b110
  } hsmon_state_t;

  // ==========================================================
  // readback formats
  typedef enum logic [1:0] {
    FMT_BOTH = 2'b00,
    FMT_VOLT = 2'b01,
    FMT_AMP = 2'b10,
    FMT_STATUS = 2'b11
  } hsmon_fmt_t;

  // ==========================================================
  // status byte
  typedef struct packed {
    logic [1:0] spare;
    logic powerDisabledSticky;
    logic powerDisabledState;
    logic swapFailedSticky;
    logic analogTripState;
    logic adcOvercurrentSticky;
    logic adcOvercurrentNow;
  } hsmon_status_t;

  // ==========================================================
  // one conversion result
  typedef struct packed {
    logic valid;
    logic [11:0] code;
  } hsmon_conv_t;

endpackage : hsmon_pkg

// ---- hsmon_readback_asserts.sv ----
/* Checker of the readback block.
   Bound to hsmon_readback; sees its ports only. */
module hsmon_readback_asserts (
  input wire logic clk,
  input wire logic nrst,
  input wire logic scl,
  input wire logic sdaOe,
  input wire logic cmdWrite,
  input wire logic [7:0] cmdData,
  input wire logic alertEnWrite,
  input wire logic [7:0] alertEnData,
  input wire logic ctrlWrite,
  input wire logic [7:0] ctrlData,
  input wire logic analogTrip,
  input wire logic swapFailEvent,
  input wire logic hotswapOff,
  input wire logic voltConvertEn,
  input wire logic ampConvertEn,
  input wire logic clearPending,
  input wire logic [7:0] statusByte
);
  // ==========================================================
  // alert enables and clear history
  logic enHs_q;
  logic enOff_q;
  logic [2:0] clrHist_q;
  always_ff @(posedge clk) begin
    if (!nrst) begin
      enHs_q <= 1'h1;
      enOff_q <= 1'h0;
    end else if (alertEnWrite) begin
      enHs_q <= alertEnData[2];
      enOff_q <= alertEnData[3];
    end
  end
  always_ff @(posedge clk) begin
    if (!nrst) clrHist_q <= 3'h0;
    else clrHist_q <= {clrHist_q[1:0], clearPending};
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);

  // ==========================================================
  // properties
  a_software_power_off_forces: assert property (ctrlWrite && ctrlData[0] |=> hotswapOff)
    else $error("software off ignored");
  a_off_bit: assert property ($past(nrst) |-> statusByte[4] == $past(hotswapOff))
    else $error("off state bit wrong");
  a_off_alert: assert property ($rose(hotswapOff) && enOff_q |-> ##[1:3] statusByte[5])
    else $error("off alert not set");
  a_trip_bit: assert property ($rose(analogTrip) |-> ##[1:4] statusByte[2])
    else $error("trip bit not set");
  a_swap_fail: assert property (swapFailEvent && enHs_q |-> ##[1:3] statusByte[3])
    else $error("swap fail not set");
  a_clear_pulse: assert property ($past(nrst) |-> clearPending == $past(alertEnWrite && alertEnData[4]))
    else $error("clear pulse wrong");
  a_clear_sticky: assert property (clearPending |-> ##[1:3] (statusByte & 8'h2A) == 8'h00)
    else $error("stickies not cleared");
  a_sticky_hold: assert property (|($past(statusByte[5:1]) & ~statusByte[5:1] & 5'h15) |-> |clrHist_q)
    else $error("sticky fell without clear");
  a_spare_zero: assert property (statusByte[7:6] == 2'h0)
    else $error("spare bits set");
  a_conv_sel: assert property (cmdWrite |=> voltConvertEn == $past(cmdData[0] | cmdData[1])
    && ampConvertEn == $past(cmdData[2] | cmdData[3]))
    else $error("convert enables wrong");
  a_sda_lowscl: assert property ($changed(sdaOe) |-> !scl)
    else $error("sda moved while scl high");

  c_clear: cover property (clearPending);
  c_swap: cover property ($rose(statusByte[3]));
  c_ack: cover property ($rose(sdaOe));
endmodule : hsmon_readback_asserts

bind hsmon_readback hsmon_readback_asserts u_asserts (.clk, .nrst, .scl, .sdaOe, .cmdWrite, .cmdData,
  .alertEnWrite, .alertEnData, .ctrlWrite, .ctrlData, .analogTrip, .swapFailEvent, .hotswapOff,
  .voltConvertEn, .ampConvertEn, .clearPending, .statusByte);

// ---- hsmon_i2c_master.sv ----
/* I2C master model reading the readback block.
   Assumes an open-drain SDA resolved by the bench with a pull-up. */
module hsmon_i2c_master (
  output logic scl,
  output logic sdaLow,
  input wire logic sda
);
  timeunit 1ns;
  timeprecision 100ps;
  logic lclk = 1'h0;
  logic acked;
  logic ackLast = 1'h0;
  logic [7:0] rd [3];

  initial begin
    scl = 1'h1;
    sdaLow = 1'h0;
  end
  initial #3.7 forever #6 lclk = ~lclk;

  // ==========================================================
  // bit timing: scl high 240 ns, low 288 ns
  task automatic half();
    repeat (20) @(posedge lclk);
  endtask : half

  task automatic pulse(input logic drv, output logic smp);
    sdaLow = drv;
    half();
    scl = 1'h1;
    smp = sda;
    half();
    scl = 1'h0;
    repeat (4) @(posedge lclk);
  endtask : pulse

  // ==========================================================
  // read transfer of n bytes
  task automatic xfer(input logic [6:0] a, input int n);
    logic [7:0] sh;
    logic s;
    sh = {a, 1'h1};
    sdaLow = 1'h1;
    half();
    scl = 1'h0;
    repeat (4) @(posedge lclk);
    for (int b = 7; b >= 0; b--) pulse(~sh[b], s);
    pulse(1'h0, s);
    acked = ~s;
    for (int k = 0; k < n && acked; k++) begin
      for (int b = 7; b >= 0; b--) pulse(1'h0, rd[k][b]);
      pulse(k < n - 1 || ackLast, s);
    end
    sdaLow = 1'h1;
    half();
    scl = 1'h1;
    half();
    sdaLow = 1'h0;
    half();
  endtask : xfer
endmodule : hsmon_i2c_master

// ---- tb_hotswap_monitor_readback_status.sv ----
/* Testbench of the readback block: strobes, conversions and I2C reads.
   Assumes the design, its checker and the master model are compiled first. */
module tb_hotswap_monitor_readback_status;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [6:0] DEV_ADDR = 7'h2A;
  logic clk = 1'h0;
  logic nrst, scl, sdaIn, mLow, powerEnablePin, voltDone, ampDone, analogTrip, swapFailEvent;
  logic sdaOut, sdaOe, hotswapOff, voltConvertEn, ampConvertEn, voltSpanSelect, clearPending;
  logic [3:0] wrSel;
  logic [7:0] wrData, statusByte;
  logic [11:0] voltCode, ampCode;
  int mismatches = 0;
  int cmp_count = 0;

  always #12.5 clk = ~clk;
  assign sdaIn = ~((sdaOe & ~sdaOut) | mLow);

  hsmon_readback dut (.clk, .nrst, .scl, .sdaIn, .sdaOut, .sdaOe, .slaveAddr(DEV_ADDR), .powerEnablePin,
    .cmdWrite(wrSel[0]), .cmdData(wrData), .alertEnWrite(wrSel[1]), .alertEnData(wrData),
    .threshWrite(wrSel[2]), .threshData(wrData), .ctrlWrite(wrSel[3]), .ctrlData(wrData),
    .voltDone, .voltCode, .ampDone, .ampCode, .analogTrip, .swapFailEvent, .hotswapOff,
    .voltConvertEn, .ampConvertEn, .voltSpanSelect, .clearPending, .statusByte);
  hsmon_i2c_master mst (.scl, .sdaLow(mLow), .sda(sdaIn));

  // ==========================================================
  // tasks
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc
  task automatic chk(input string nm, input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic put(input int k, input logic [7:0] d);
    cyc(1);
    wrSel = 4'h1 << k;
    wrData = d;
    cyc(1);
    wrSel = 4'h0;
  endtask : put
  task automatic conv(input logic isVolt, input logic [11:0] c);
    cyc(1);
    voltDone = isVolt;
    ampDone = ~isVolt;
    voltCode = c;
    ampCode = c;
    cyc(1);
    voltDone = 1'h0;
    ampDone = 1'h0;
  endtask : conv
  task automatic rd(input logic [6:0] a, input int n, input logic ak, input logic [23:0] exp);
    mst.xfer(a, n);
    chk("address ack", mst.acked, ak);
    for (int k = 0; k < n && ak; k++) chk("read byte", mst.rd[k], exp[23 - 8 * k -: 8]);
  endtask : rd
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : conclude

  initial begin
    #1000000;
    mismatches++;
    conclude();
  end

  // ==========================================================
  // tests
  initial begin
    nrst = 1'h0;
    powerEnablePin = 1'h1;
    wrSel = 4'h0;
    wrData = 8'h00;
    voltDone = 1'h0;
    ampDone = 1'h0;
    voltCode = 12'h000;
    ampCode = 12'h000;
    analogTrip = 1'h0;
    swapFailEvent = 1'h0;
    cyc(4);
    nrst = 1'h1;
    cyc(4);
    chk("hot swap off", hotswapOff, 8'h00);
    chk("status", statusByte, 8'h00);
    put(0, 8'h05);
    rd(DEV_ADDR, 3, 1'h1, 24'h000000);
    conv(1'h1, 12'hA5C);
    conv(1'h0, 12'h3B7);
    put(0, 8'h15);
    chk("volt span", voltSpanSelect, 8'h01);
    rd(DEV_ADDR, 3, 1'h1, 24'hA53BC7);
    put(0, 8'h01);
    chk("volt span", voltSpanSelect, 8'h00);
    rd(DEV_ADDR, 2, 1'h1, 24'hA5C000);
    put(0, 8'h04);
    rd(DEV_ADDR, 2, 1'h1, 24'h3B7000);
    rd(DEV_ADDR ^ 7'h01, 2, 1'h0, 24'h000000);
    put(0, 8'h02);
    chk("volt convert", voltConvertEn, 8'h01);
    rd(DEV_ADDR, 2, 1'h0, 24'h000000);
    conv(1'h1, 12'h123);
    chk("volt convert", voltConvertEn, 8'h00);
    put(0, 8'h08);
    rd(DEV_ADDR, 2, 1'h0, 24'h000000);
    conv(1'h0, 12'h456);
    rd(DEV_ADDR, 3, 1'h1, 24'h124536);
    put(1, 8'h0C);
    put(3, 8'h01);
    chk("hot swap off", hotswapOff, 8'h01);
    cyc(2);
    chk("status", statusByte, 8'h30);
    put(3, 8'h00);
    cyc(2);
    chk("status", statusByte, 8'h20);
    powerEnablePin = 1'h0;
    cyc(4);
    chk("status", statusByte, 8'h30);
    powerEnablePin = 1'h1;
    analogTrip = 1'h1;
    swapFailEvent = 1'h1;
    cyc(1);
    swapFailEvent = 1'h0;
    cyc(4);
    chk("status", statusByte, 8'h2C);
    put(0, 8'h40);
    mst.ackLast = 1'h1;
    rd(DEV_ADDR, 1, 1'h1, 24'h2C0000);
    mst.ackLast = 1'h0;
    rd(DEV_ADDR, 1, 1'h1, 24'h2C0000);
    analogTrip = 1'h0;
    put(1, 8'h1C);
    chk("clear pending", clearPending, 8'h01);
    cyc(1);
    chk("clear pending", clearPending, 8'h00);
    cyc(2);
    chk("status", statusByte, 8'h00);
    put(2, 8'h80);
    put(1, 8'h01);
    conv(1'h0, 12'h810);
    cyc(3);
    chk("status", statusByte, 8'h02);
    conv(1'h0, 12'h810);
    conv(1'h0, 12'h810);
    cyc(3);
    chk("status", statusByte, 8'h03);
    conv(1'h0, 12'h800);
    cyc(3);
    chk("status", statusByte, 8'h02);
    put(1, 8'h10);
    cyc(3);
    chk("status", statusByte, 8'h00);
    conclude();
  end
endmodule : tb_hotswap_monitor_readback_status
